// [dcs_cfg.svh]
// timing counts, pin encodings and widths of the ddr3 command sequencer
`ifndef DCS_CFG_SVH
`define DCS_CFG_SVH
`define DCS_CLK_NS      40
`define DCS_ADDR_W      14
`define DCS_BA_W        3
`define DCS_DQ_W        8
`define DCS_BEATS       8
`define DCS_CNT_W       11
`define DCS_OWED_MAX    4'h8
`define DCS_TREFI_NS    7800
`define DCS_TREFI_X_NS  3900
`define DCS_TRP_NS      15
`define DCS_TRCD_NS     15
`define DCS_TRFC_NS     160
`define DCS_TXS_NS      170
`define DCS_TWR_NS      15
`define DCS_ZQINIT_CK   512
`define DCS_ZQOPER_CK   256
`define DCS_ZQCS_CK     64
`define DCS_VREF_CK     512
`define DCS_CL_CK       6
`define DCS_CWL_CK      5
`define DCS_RD_SYNC     4
// longest times round down, least times round up; one link clock is two system cycles
`define DCS_TREFI_CYC   (`DCS_TREFI_NS / `DCS_CLK_NS)
`define DCS_TREFI_X_CYC (`DCS_TREFI_X_NS / `DCS_CLK_NS)
`define DCS_TRP_CYC     ((`DCS_TRP_NS + `DCS_CLK_NS - 1) / `DCS_CLK_NS)
`define DCS_TRCD_CYC    ((`DCS_TRCD_NS + `DCS_CLK_NS - 1) / `DCS_CLK_NS)
`define DCS_TRFC_CYC    ((`DCS_TRFC_NS + `DCS_CLK_NS - 1) / `DCS_CLK_NS)
`define DCS_TXS_CYC     ((`DCS_TXS_NS + `DCS_CLK_NS - 1) / `DCS_CLK_NS)
`define DCS_TWR_CYC     ((`DCS_TWR_NS + `DCS_CLK_NS - 1) / `DCS_CLK_NS)
// command pins {cs_n, ras_n, cas_n, we_n}
`define DCS_CMD_DES     4'hF
`define DCS_CMD_NOP     4'h7
`define DCS_CMD_ACT     4'h3
`define DCS_CMD_RD      4'h5
`define DCS_CMD_WR      4'h4
`define DCS_CMD_PRE     4'h2
`define DCS_CMD_REF     4'h1
`define DCS_CMD_ZQ      4'h6
`endif

// [dcs_ctrl.sv]
// ddr3 command sequencer: drives activate, read, write, precharge, refresh, zq, self refresh
//Behaviour
//- first long zq waits init window, later oper
//- precharge bank before opening another row
//- never interrupt a running burst
//- mask high leaves byte unwritten
//- next access waits until transfer ends
//- refresh every 7.8us, 3.9us extended
//- at most eight refreshes owed
//- owed count kept across self refresh
//- only deselect after refresh; cke high
//- precharge all before refresh
//- wait 512 clocks after vref before write
`timescale 1ns/1ps
`include "dcs_cfg.svh"
module dcs_ctrl
	import dcs_pkg::*;
(
	input  wire logic                        clk_sys,
	input  wire logic                        arst_n,
	input  wire logic                        ce,
	input  wire logic                        temp_ext,
	input  wire logic                        vref_floated,
	input  wire logic                        req_valid,
	output logic                             req_ready,
	input  wire logic [2:0]                  req_op,
	input  wire logic [`DCS_BA_W-1:0]        req_bank,
	input  wire logic [`DCS_ADDR_W-1:0]      req_row,
	input  wire logic [9:0]                  req_col,
	input  wire logic                        req_ap,
	input  wire logic                        req_chop,
	input  wire logic [63:0]                 req_wdata,
	input  wire logic [7:0]                  req_wmask,
	output logic [63:0]                      rd_data,
	output logic                             rd_valid,
	output logic [3:0]                       owed,
	output logic                             ck_o,
	output logic                             cke_o,
	output logic                             cs_n_o,
	output logic                             ras_n_o,
	output logic                             cas_n_o,
	output logic                             we_n_o,
	output logic [`DCS_BA_W-1:0]             ba_o,
	output logic [`DCS_ADDR_W-1:0]           addr_o,
	input  wire logic [`DCS_DQ_W-1:0]        dq_i,
	output logic [`DCS_DQ_W-1:0]             dq_o,
	output logic                             dq_oe,
	output logic                             dm_o
);
	dcs_state_e                 state_r, state_nxt;
	dcs_op_e                    op_r, op_nxt;
	logic                       ph_r;
	logic [`DCS_CNT_W-1:0]      wait_r, wait_nxt, refi_r, refi_nxt, vref_r, vref_nxt;
	logic [3:0]                 owed_r, owed_nxt, beat_r, beat_nxt;
	logic [3:0]                 cmd_r, cmd_nxt;
	logic                       cke_r, cke_nxt, zq_init_r, zq_init_nxt;
	logic [`DCS_BA_W-1:0]       ba_r, ba_nxt, bk_r, bk_nxt;
	logic [`DCS_ADDR_W-1:0]     addr_r, addr_nxt, row_q_r, row_q_nxt;
	logic [9:0]                 col_r, col_nxt;
	logic                       ap_r, ap_nxt, chop_r, chop_nxt;
	logic [63:0]                wdata_r, wdata_nxt, rbuf_r, rbuf_nxt, rd_data_r, rd_data_nxt;
	logic [7:0]                 wmask_r, wmask_nxt, open_r, open_nxt, hit;
	logic [7:0][`DCS_ADDR_W-1:0] row_r, row_nxt;
	logic                       rd_valid_r, rd_valid_nxt, oe_r, oe_nxt, dm_r, dm_nxt;
	logic [`DCS_DQ_W-1:0]       dqo_r, dqo_nxt;
	logic [`DCS_DQ_W-1:0]       s1_r, s2_r, s3_r;
	logic                       slot, ref_due, last_beat;
	logic [`DCS_CNT_W-1:0]      refi_lim;

	// per bank row-hit
	genvar g;
	generate
		for (g = 0; g < 8; g++) begin : g_bank
			assign hit[g] = open_r[g] && (row_r[g] == row_q_r);
		end
	endgenerate

	assign slot      = ph_r && (wait_r == '0);
	assign refi_lim  = temp_ext ? `DCS_CNT_W'(`DCS_TREFI_X_CYC) : `DCS_CNT_W'(`DCS_TREFI_CYC);
	// owed refreshes are served before a calibration, whose window blocks them for long
	assign ref_due   = (owed_r == `DCS_OWED_MAX) || ((owed_r != 4'h0)
		&& (!req_valid || req_op == OP_ZQL || req_op == OP_ZQS));
	assign last_beat = beat_r == (chop_r ? 4'h3 : 4'h7);
	assign req_ready = (state_r == S_IDLE) && slot && !ref_due && !cke_r == 1'b0
		&& !(req_op == OP_WR && vref_r != '0)
		&& (req_op != OP_SRX) && (req_op != OP_REF);

	always_comb begin
		state_nxt = state_r;
		op_nxt = op_r;
		wait_nxt = (wait_r != '0) ? wait_r - `DCS_CNT_W'(1) : wait_r;
		refi_nxt = refi_r;
		vref_nxt = (vref_r != '0) ? vref_r - `DCS_CNT_W'(1) : vref_r;
		owed_nxt = owed_r;
		beat_nxt = beat_r;
		cmd_nxt = cmd_r;
		cke_nxt = cke_r;
		ba_nxt = ba_r;
		addr_nxt = addr_r;
		zq_init_nxt = zq_init_r;
		{bk_nxt, row_q_nxt, col_nxt, ap_nxt, chop_nxt} = {bk_r, row_q_r, col_r, ap_r, chop_r};
		wdata_nxt = wdata_r;
		wmask_nxt = wmask_r;
		rbuf_nxt = rbuf_r;
		rd_data_nxt = rd_data_r;
		open_nxt = open_r;
		row_nxt = row_r;
		rd_valid_nxt = 1'b0;
		oe_nxt = 1'b0;
		dm_nxt = 1'b0;
		dqo_nxt = dqo_r;
		// owed count stops while the device refreshes itself
		if (refi_r >= refi_lim - `DCS_CNT_W'(1)) begin
			refi_nxt = '0;
			if (state_r != S_SR && owed_r != `DCS_OWED_MAX)
				owed_nxt = owed_r + 4'h1;
		end else begin
			refi_nxt = refi_r + `DCS_CNT_W'(1);
		end
		// command pins change only as the link clock falls, so they are stable at its rise
		if (ph_r)
			cmd_nxt = (state_r == S_IDLE) ? `DCS_CMD_DES : `DCS_CMD_NOP;
		case (state_r)
			S_IDLE: begin
				if (slot && ref_due) begin
					op_nxt = OP_REF;
					state_nxt = S_CLOSE;
				end else if (req_valid && req_ready) begin
					op_nxt = dcs_op_e'(req_op);
					{bk_nxt, row_q_nxt, col_nxt} = {req_bank, req_row, req_col};
					{ap_nxt, chop_nxt, wdata_nxt, wmask_nxt} = {req_ap, req_chop, req_wdata, req_wmask};
					if (req_op == OP_RD || req_op == OP_WR) begin
						if (open_r[req_bank] && row_r[req_bank] == req_row)
							state_nxt = S_CMD;
						else if (open_r[req_bank])
							state_nxt = S_PRE;
						else
							state_nxt = S_ACT;
					end else begin
						state_nxt = S_CLOSE;
					end
				end
			end
			S_PRE: if (slot) begin
				cmd_nxt = `DCS_CMD_PRE;
				ba_nxt = bk_r;
				addr_nxt = '0;
				open_nxt[bk_r] = 1'b0;
				wait_nxt = `DCS_CNT_W'(`DCS_TRP_CYC);
				state_nxt = S_ACT;
			end
			S_ACT: if (slot && !hit[bk_r]) begin
				cmd_nxt = `DCS_CMD_ACT;
				ba_nxt = bk_r;
				addr_nxt = row_q_r;
				open_nxt[bk_r] = 1'b1;
				row_nxt[bk_r] = row_q_r;
				wait_nxt = `DCS_CNT_W'(`DCS_TRCD_CYC);
				state_nxt = S_CMD;
			end
			S_CMD: if (slot) begin
				cmd_nxt = (op_r == OP_WR) ? `DCS_CMD_WR : `DCS_CMD_RD;
				ba_nxt = bk_r;
				addr_nxt = '0;
				addr_nxt[9:0] = col_r;
				addr_nxt[10] = ap_r;
				addr_nxt[12] = !chop_r;
				wait_nxt = (op_r == OP_WR) ? `DCS_CNT_W'(2 * `DCS_CWL_CK)
					: `DCS_CNT_W'(2 * `DCS_CL_CK + `DCS_RD_SYNC);
				beat_nxt = 4'h0;
				rbuf_nxt = '0;
				state_nxt = S_DATA;
			end
			S_DATA: if (wait_r == '0) begin
				// one beat per link clock half; no command may cut it short
				beat_nxt = beat_r + 4'h1;
				if (op_r == OP_WR) begin
					oe_nxt = 1'b1;
					dqo_nxt = wdata_r[beat_r[2:0]*8 +: 8];
					dm_nxt = wmask_r[beat_r[2:0]];
				end else begin
					// beats change every cycle, so they are taken from the third stage
					rbuf_nxt[beat_r[2:0]*8 +: 8] = s3_r;
				end
				if (last_beat) begin
					if (op_r == OP_RD) begin
						rd_data_nxt = rbuf_nxt;
						rd_valid_nxt = 1'b1;
					end
					if (ap_r) begin
						open_nxt[bk_r] = 1'b0;
						wait_nxt = `DCS_CNT_W'(`DCS_TWR_CYC + `DCS_TRP_CYC);
					end
					state_nxt = S_IDLE;
				end
			end
			S_CLOSE: if (slot) begin
				if (open_r != 8'h00) begin
					cmd_nxt = `DCS_CMD_PRE;
					addr_nxt = '0;
					addr_nxt[10] = 1'b1;
					open_nxt = 8'h00;
					wait_nxt = `DCS_CNT_W'(`DCS_TRP_CYC);
				end else if (op_r == OP_REF) begin
					cmd_nxt = `DCS_CMD_REF;
					owed_nxt = owed_nxt - 4'h1;
					wait_nxt = `DCS_CNT_W'(`DCS_TRFC_CYC);
					state_nxt = S_IDLE;
				end else if (op_r == OP_SRE) begin
					cmd_nxt = `DCS_CMD_REF;
					cke_nxt = 1'b0;
					state_nxt = S_SR;
				end else begin
					cmd_nxt = `DCS_CMD_ZQ;
					addr_nxt = '0;
					addr_nxt[10] = (op_r == OP_ZQL);
					if (op_r == OP_ZQS)
						wait_nxt = `DCS_CNT_W'(2 * `DCS_ZQCS_CK);
					else if (!zq_init_r)
						wait_nxt = `DCS_CNT_W'(2 * `DCS_ZQINIT_CK);
					else
						wait_nxt = `DCS_CNT_W'(2 * `DCS_ZQOPER_CK);
					zq_init_nxt = zq_init_r | (op_r == OP_ZQL);
					state_nxt = S_IDLE;
				end
			end
			S_SR: if (slot && req_valid && req_op == OP_SRX) begin
				// exit is a plain cke rise with nop, no clock history assumed
				cke_nxt = 1'b1;
				wait_nxt = `DCS_CNT_W'(`DCS_TXS_CYC);
				if (vref_floated)
					vref_nxt = `DCS_CNT_W'(2 * `DCS_VREF_CK);
				state_nxt = S_IDLE;
			end
			default: state_nxt = S_IDLE;
		endcase
	end

	always_ff @(posedge clk_sys or negedge arst_n) begin
		if (!arst_n) begin
			state_r <= S_IDLE;
			op_r <= OP_RD;
			ph_r <= 1'b0;
			{wait_r, refi_r, vref_r} <= '0;
			{owed_r, beat_r} <= '0;
			cmd_r <= `DCS_CMD_DES;
			cke_r <= 1'b1;
			{ba_r, addr_r, bk_r, row_q_r, col_r, ap_r, chop_r} <= '0;
			{wdata_r, wmask_r, rbuf_r, rd_data_r, rd_valid_r} <= '0;
			{open_r, row_r, zq_init_r} <= '0;
			{oe_r, dm_r, dqo_r} <= '0;
			{s1_r, s2_r, s3_r} <= '0;
		end else if (ce) begin
			state_r <= state_nxt;
			op_r <= op_nxt;
			ph_r <= !ph_r;
			{wait_r, refi_r, vref_r} <= {wait_nxt, refi_nxt, vref_nxt};
			{owed_r, beat_r} <= {owed_nxt, beat_nxt};
			cmd_r <= cmd_nxt;
			cke_r <= cke_nxt;
			{ba_r, addr_r, bk_r, row_q_r, col_r} <= {ba_nxt, addr_nxt, bk_nxt, row_q_nxt, col_nxt};
			{ap_r, chop_r, wdata_r, wmask_r} <= {ap_nxt, chop_nxt, wdata_nxt, wmask_nxt};
			{rbuf_r, rd_data_r, rd_valid_r} <= {rbuf_nxt, rd_data_nxt, rd_valid_nxt};
			{open_r, row_r, zq_init_r} <= {open_nxt, row_nxt, zq_init_nxt};
			{oe_r, dm_r, dqo_r} <= {oe_nxt, dm_nxt, dqo_nxt};
			s1_r <= dq_i;
			s2_r <= s1_r;
			s3_r <= s2_r;
		end
	end

	assign {cs_n_o, ras_n_o, cas_n_o, we_n_o} = cmd_r;
	assign ck_o = ph_r;
	assign cke_o = cke_r;
	assign ba_o = ba_r;
	assign addr_o = addr_r;
	assign dq_o = dqo_r;
	assign dq_oe = oe_r;
	assign dm_o = dm_r;
	assign rd_data = rd_data_r;
	assign rd_valid = rd_valid_r;
	assign owed = owed_r;

	logic [3:0] pin_cmd;
	assign pin_cmd = {cs_n_o, ras_n_o, cas_n_o, we_n_o};
	sequence s_ref_issued;
		pin_cmd == `DCS_CMD_REF && cke_o ##1 pin_cmd == `DCS_CMD_REF;
	endsequence
	sequence s_quiet;
		pin_cmd == `DCS_CMD_NOP || pin_cmd == `DCS_CMD_DES;
	endsequence
	AST_REF_QUIET: assert property (@(posedge clk_sys) disable iff (!arst_n)
		s_ref_issued |=> s_quiet [*4]) else $error("command issued inside refresh cycle");
	AST_CKE_HIGH: assert property (@(posedge clk_sys) disable iff (!arst_n)
		(pin_cmd == `DCS_CMD_PRE || pin_cmd == `DCS_CMD_ACT) |-> cke_o)
		else $error("cke low with precharge or activate");
	AST_ACT_CLOSED: assert property (@(posedge clk_sys) disable iff (!arst_n)
		(state_r == S_ACT && slot && ce) |-> !open_r[bk_r])
		else $error("activate to a bank with an open row");
	AST_REF_ALLCLOSED: assert property (@(posedge clk_sys) disable iff (!arst_n)
		(pin_cmd == `DCS_CMD_REF) |-> open_r == 8'h00) else $error("refresh with open bank");
	AST_OWED_CAP: assert property (@(posedge clk_sys) disable iff (!arst_n)
		owed_r == `DCS_OWED_MAX |-> ##[1:120] pin_cmd == `DCS_CMD_REF)
		else $error("eight owed refreshes not served");
	AST_VREF_HOLD: assert property (@(posedge clk_sys) disable iff (!arst_n)
		(pin_cmd == `DCS_CMD_WR) |-> vref_r == '0) else $error("write before vref settle");
	AST_BURST_WHOLE: assert property (@(posedge clk_sys) disable iff (!arst_n)
		(state_r == S_DATA) |-> !(pin_cmd inside {`DCS_CMD_RD, `DCS_CMD_WR, `DCS_CMD_PRE})
		|| $past(state_r) == S_CMD || $past(state_r, 2) == S_CMD)
		else $error("burst interrupted");
	AST_MASK_BEAT: assert property (@(posedge clk_sys) disable iff (!arst_n)
		(state_r == S_DATA && op_r == OP_WR && wait_r == '0 && ce)
		|=> dq_oe && dm_o == $past(wmask_r[beat_r[2:0]])) else $error("mask beat mismatch");
	AST_ZQ_FIRST: assert property (@(posedge clk_sys) disable iff (!arst_n)
		(state_r == S_CLOSE && state_nxt == S_IDLE && op_r == OP_ZQL && !zq_init_r && ce)
		|=> wait_r == `DCS_CNT_W'(2 * `DCS_ZQINIT_CK)) else $error("zq init window wrong");
endmodule // dcs_ctrl

// [dcs_mem_model.sv]
// behavioural ddr3 device answering the command sequencer
`timescale 1ns/1ps
`include "dcs_cfg.svh"
module dcs_mem_model
	import dcs_pkg::*;
(
	input  wire logic        ck,
	input  wire logic        cke,
	input  wire logic        cs_n,
	input  wire logic        ras_n,
	input  wire logic        cas_n,
	input  wire logic        we_n,
	input  wire logic [2:0]  ba,
	input  wire logic [13:0] addr,
	input  wire logic [7:0]  dq_in,
	input  wire logic        dq_oe,
	input  wire logic        dm,
	input  wire logic        vref_floated,
	output logic [7:0]       dq,
	output int               err,
	output int               refs,
	output int               zqs
);
	logic [7:0]  mem [int];
	logic [13:0] row_r [8];
	logic [7:0]  open_r = 8'h00;
	logic [2:0]  rd_ba, wr_ba;
	logic        rd_ap, wr_ap, cke_q = 1'b1, zql_seen = 1'b0;
	int          key, wkey, rd_wait = 0, rd_left = 0, wr_left = 0;
	int          since_ref = 99, since_srx = 9999, since_zq = 0, zq_win = 0;
	initial begin
		dq = 8'h00;
		err = 0;
		refs = 0;
		zqs = 0;
	end
	always @(posedge ck) begin
		cke_q <= cke;
		since_ref++;
		since_srx++;
		since_zq++;
		if (cke && !cke_q) since_srx = 0;
		if (cke_q && !cs_n) begin
			if ({ras_n, cas_n, we_n} != 3'h7 && (since_ref < 2 || since_zq < zq_win)) err++;
			case ({cs_n, ras_n, cas_n, we_n})
				`DCS_CMD_ACT: begin
					if (open_r[ba]) err++;
					open_r[ba] = 1'b1;
					row_r[ba] = addr;
				end
				`DCS_CMD_PRE: begin
					if (addr[10]) open_r = 8'h00;
					else open_r[ba] = 1'b0;
				end
				`DCS_CMD_RD: begin
					if (!open_r[ba]) err++;
					key = {ba, row_r[ba], addr[9:0]};
					rd_wait = 2 * `DCS_CL_CK;
					rd_left = addr[12] ? 8 : 4;
					rd_ap = addr[10];
					rd_ba = ba;
				end
				`DCS_CMD_WR: begin
					if (!open_r[ba] || (vref_floated && since_srx < `DCS_VREF_CK)) err++;
					wkey = {ba, row_r[ba], addr[9:0]};
					wr_left = addr[12] ? 8 : 4;
					wr_ap = addr[10];
					wr_ba = ba;
				end
				`DCS_CMD_REF: begin
					if (|open_r) err++;
					refs++;
					since_ref = 0;
				end
				`DCS_CMD_ZQ: begin
					if (|open_r) err++;
					zqs++;
					since_zq = 0;
					zq_win = !addr[10] ? `DCS_ZQCS_CK : zql_seen ? `DCS_ZQOPER_CK : `DCS_ZQINIT_CK;
					zql_seen = zql_seen | addr[10];
				end
				default: ;
			endcase
		end
	end
	// data moves on both link edges; idle lines show a changing pattern, held still while a read waits out its latency
	always @(ck) begin
		#5;
		if (dq_oe && wr_left > 0) begin
			if (dm === 1'b0) mem[wkey] = dq_in;
			wkey++;
			wr_left--;
			if (wr_left == 0 && wr_ap) open_r[wr_ba] = 1'b0;
		end
		if (rd_wait > 0) rd_wait--;
		else if (rd_left > 0) begin
			dq = mem.exists(key) ? mem[key] : 8'hEE;
			key++;
			rd_left--;
			if (rd_left == 0 && rd_ap) open_r[rd_ba] = 1'b0;
		end
		else dq = ~dq;
	end
endmodule // dcs_mem_model

// [dcs_pkg.sv]
// types of the ddr3 command sequencer
package dcs_pkg;
	typedef enum logic [3:0] {
		S_IDLE  = 4'h0,
		S_PRE   = 4'h1,
		S_ACT   = 4'h2,
		S_CMD   = 4'h3,
		S_DATA  = 4'h4,
		S_CLOSE = 4'h5,
		S_SR    = 4'h6
	} dcs_state_e;
	typedef enum logic [2:0] {
		OP_RD  = 3'h0,
		OP_WR  = 3'h1,
		OP_ZQL = 3'h2,
		OP_ZQS = 3'h3,
		OP_SRE = 3'h4,
		OP_SRX = 3'h5,
		OP_REF = 3'h6
	} dcs_op_e;
endpackage

// [tb.sv]
// self-checking bench of the ddr3 command sequencer with a device model
`timescale 1ns/1ps
`include "dcs_cfg.svh"
module tb
	import dcs_pkg::*;
;
	logic        clk_sys = 1'b0, arst_n = 1'b0, ce = 1'b1, temp_ext = 1'b0, vref_floated = 1'b0;
	logic        req_valid = 1'b0, req_ap = 1'b0, req_chop = 1'b0;
	logic [2:0]  req_op = 3'h0, req_bank = 3'h0, ba_o;
	logic [13:0] req_row = 14'h0000, addr_o, last_rd_a;
	logic [9:0]  req_col = 10'h000;
	logic [63:0] req_wdata = 64'h0, rd_data, rdv;
	logic [7:0]  req_wmask = 8'h00, dq_o, m_dq, dq_w;
	logic [3:0]  owed;
	logic        req_ready, rd_valid, ck_o, cke_o, cs_n_o, ras_n_o, cas_n_o, we_n_o, dq_oe, dm_o;
	int          n_fail = 0, checks = 0, err, refs, zqs, r0;
	assign dq_w = dq_oe ? dq_o : m_dq;
	dcs_ctrl u_dut (.clk_sys, .arst_n, .ce, .temp_ext, .vref_floated, .req_valid, .req_ready,
		.req_op, .req_bank, .req_row, .req_col, .req_ap, .req_chop, .req_wdata, .req_wmask,
		.rd_data, .rd_valid, .owed, .ck_o, .cke_o, .cs_n_o, .ras_n_o, .cas_n_o, .we_n_o,
		.ba_o, .addr_o, .dq_i(dq_w), .dq_o, .dq_oe, .dm_o);
	dcs_mem_model u_mem (.ck(ck_o), .cke(cke_o), .cs_n(cs_n_o), .ras_n(ras_n_o),
		.cas_n(cas_n_o), .we_n(we_n_o), .ba(ba_o), .addr(addr_o), .dq_in(dq_w),
		.dq_oe, .dm(dm_o), .vref_floated, .dq(m_dq), .err, .refs, .zqs);
	initial forever #20 clk_sys = ~clk_sys;
	always @(posedge ck_o) if ({cs_n_o, ras_n_o, cas_n_o, we_n_o} == `DCS_CMD_RD) last_rd_a <= addr_o;
	task automatic close_out();
		if (n_fail == 0 && checks > 0) $display("Simulation passed");
		else $display("Simulation failed");
		$finish;
	endtask
	task automatic chk(input logic ok, input string m);
		checks++;
		if (ok !== 1'b1) begin
			n_fail++;
			$display("wrong value at %0t: %s", $time, m);
		end
	endtask
	task automatic req(input logic [2:0] op, input logic [2:0] b, input logic [13:0] r,
		input logic [9:0] c, input logic a, input logic ch, input logic [63:0] d,
		input logic [7:0] m);
		int i;
		@(negedge clk_sys);
		{req_op, req_bank, req_row, req_col, req_ap, req_chop, req_wdata, req_wmask} =
			{op, b, r, c, a, ch, d, m};
		req_valid = 1'b1;
		#1;
		for (i = 0; i < 3000 && req_ready !== 1'b1; i++) @(negedge clk_sys);
		chk(i < 3000, "request not taken");
		@(negedge clk_sys);
		req_valid = 1'b0;
	endtask
	task automatic rd(input logic [2:0] b, input logic [13:0] r, input logic [9:0] c,
		input logic a, input logic ch);
		int i;
		req(OP_RD, b, r, c, a, ch, 64'h0, 8'h00);
		for (i = 0; i < 500 && rd_valid !== 1'b1; i++) @(negedge clk_sys);
		chk(i < 500, "no read data");
		rdv = rd_data;
	endtask
	task automatic t_mask();
		req(OP_WR, 3'h2, 14'h0005, 10'h008, 1'b0, 1'b0, 64'h8877665544332211, 8'h24);
		rd(3'h2, 14'h0005, 10'h008, 1'b0, 1'b0);
		chk(rdv === 64'h8877EE5544EE2211, "masked write");
		chk(last_rd_a[12] === 1'b1 && last_rd_a[10] === 1'b0, "read flags");
		chk(last_rd_a[9:0] === 10'h008, "read column");
	endtask
	task automatic t_rows();
		req(OP_WR, 3'h3, 14'h0007, 10'h010, 1'b1, 1'b1, 64'hFFFFFFFFA4A3A2A1, 8'h00);
		rd(3'h3, 14'h0007, 10'h010, 1'b1, 1'b1);
		chk(rdv === 64'h00000000A4A3A2A1, "chopped burst");
		chk(last_rd_a[12] === 1'b0 && last_rd_a[10] === 1'b1, "read flags");
		rd(3'h3, 14'h0009, 10'h000, 1'b0, 1'b0);
		chk(rdv === {8{8'hEE}}, "fresh row");
		rd(3'h3, 14'h0007, 10'h010, 1'b0, 1'b1);
		chk(rdv === 64'h00000000A4A3A2A1, "reopened row");
		chk(err === 0, "bank protocol");
	endtask
	task automatic t_zq();
		r0 = zqs;
		req(OP_ZQL, 3'h0, 14'h0000, 10'h000, 1'b0, 1'b0, 64'h0, 8'h00);
		req(OP_ZQL, 3'h0, 14'h0000, 10'h000, 1'b0, 1'b0, 64'h0, 8'h00);
		req(OP_ZQS, 3'h0, 14'h0000, 10'h000, 1'b0, 1'b0, 64'h0, 8'h00);
		rd(3'h2, 14'h0005, 10'h008, 1'b0, 1'b0);
		chk(rdv === 64'h8877EE5544EE2211 && zqs - r0 == 3, "zq sequence");
		chk(err === 0, "zq window");
	endtask
	task automatic t_ref(input logic x, input int n);
		int t;
		t = x ? `DCS_TREFI_X_CYC : `DCS_TREFI_CYC;
		r0 = refs;
		temp_ext = x;
		repeat (n) @(negedge clk_sys);
		chk(refs - r0 >= n / t - 1 && refs - r0 <= n / t + 8, "refresh rate");
		chk(owed <= 4'h1 && err === 0, "refresh upkeep");
	endtask
	task automatic t_sr();
		int i;
		logic [3:0] o;
		realtime t0;
		vref_floated = 1'b1;
		req(OP_SRE, 3'h0, 14'h0000, 10'h000, 1'b0, 1'b0, 64'h0, 8'h00);
		repeat (20) @(negedge clk_sys);
		o = owed;
		r0 = refs;
		chk(cke_o === 1'b0, "self refresh entry");
		repeat (300) @(negedge clk_sys);
		chk(owed === o && refs == r0, "owed frozen");
		req_op = OP_SRX;
		req_valid = 1'b1;
		for (i = 0; i < 200 && cke_o !== 1'b1; i++) @(negedge clk_sys);
		chk(i < 200, "self refresh exit");
		req_valid = 1'b0;
		t0 = $realtime;
		req(OP_WR, 3'h4, 14'h000B, 10'h000, 1'b0, 1'b0, 64'h0123456789ABCDEF, 8'h00);
		chk($realtime - t0 > 1000.0 * `DCS_CLK_NS, "write hold");
		rd(3'h4, 14'h000B, 10'h000, 1'b0, 1'b0);
		chk(rdv === 64'h0123456789ABCDEF && err === 0, "write after exit");
		vref_floated = 1'b0;
	endtask
	task automatic t_ce();
		logic [3:0] o;
		logic k;
		ce = 1'b0;
		o = owed;
		k = ck_o;
		repeat (301) @(negedge clk_sys);
		chk(owed === o && ck_o === k && cs_n_o === 1'b1, "clock enable hold");
		ce = 1'b1;
	endtask
	initial begin
		repeat (8) @(negedge clk_sys);
		chk({cs_n_o, ras_n_o, cas_n_o, we_n_o, cke_o, dq_oe, rd_valid, owed} === 11'h7C0, "reset");
		repeat (8) @(negedge clk_sys);
		arst_n = 1'b1;
		repeat (4) @(negedge clk_sys);
		t_mask();
		t_rows();
		t_zq();
		t_ref(1'b0, 645);
		t_ref(1'b1, 645);
		t_ce();
		t_sr();
		chk(err === 0, "device protocol");
		close_out();
	end
	initial begin
		#1000000;
		n_fail++;
		close_out();
	end
endmodule // tb
